/* File: hw/pcm_map.svh */
// register offsets, field positions, reset values and timing counts for the clock mode unit
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH
`define PCM_OFF_FLAG 4'h0
`define PCM_OFF_IRQEN 4'h1
`define PCM_OFF_OSC 4'h2
`define PCM_OFF_WDOG 4'h3
`define PCM_OFF_SYN 4'h4
`define PCM_OFF_POST 4'h5
`define PCM_OFF_CLKS 4'h6
`define PCM_FLG_SETTLE_CHG 0
`define PCM_FLG_SETTLED 1
`define PCM_FLG_OSC_CHG 2
`define PCM_FLG_OSC_QUAL 3
`define PCM_IRQ_SETTLE 0
`define PCM_IRQ_OSC 1
`define PCM_OSC_ENABLE 7
`define PCM_OSC_WIDE 5
`define PCM_RST_SYN 6'h1f
`define PCM_RST_POST 5'h03
`define PCM_RST_FILT 5'h00
`define PCM_LOCK_CYCLES 8'h40
`define PCM_QUAL_EDGES 4'h8
`endif

/* File: hw/pcm_pkg.sv */
// types for the clock mode unit
package pcm_pkg;
  typedef enum logic [1:0] {PCM_PEI, PCM_PEE, PCM_PBE} pcm_mode_t;
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } pcm_bus_req_t;
endpackage

/* File: hw/pcm_clock_mode.sv */
// clock mode control, oscillator spike filter and noise detector, reset enables
//
// Functional notes
// - unfilterable noise clears qualified and settled, sets both change flags
// - settle lost through noise: pll clock is vco divided by four
// - enabled filter samples crystal input on vco clock
// - edge window three vco cycles when wide, else one
// - ratio selects filter and detection per table, detect gated by width
// - reset gives internal ref pll mode, multiplier 0x1f, post divider 0x03
// - internal ref mode clocks watchdog and tick from internal reference
// - qualified status clears whenever settled clears
// - external mode losing qualification: pll clock vco/4 until settled
// - bypass losing qualification sets bus select automatically
// - bypass: filter blocks overshoot, bus clock pauses until pll restabilises
// - clock monitor reset only while oscillator enable set
// - watchdog reset only when watchdog rate field is nonzero
// - pll bus source: bus clock is half the pll output
// - vco equals twice reference times multiplier plus one
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pcm_map.svh"
module pcm_clock_mode (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic vco_clock,
  input wire logic vco_reset,
  input wire logic pll_locked,
  input wire logic crystal_input,
  input wire logic clock_monitor_fail,
  input wire logic watchdog_timeout,
  output logic ext_osc_clock,
  output logic pll_out_clock,
  output logic bus_clock,
  output logic [1:0] mode,
  output logic ref_is_external,
  output logic wdog_tick_internal_ref,
  output logic clock_monitor_reset,
  output logic watchdog_reset,
  output logic [7:0] vco_multiplier
);
  // ==========================================================
  // register file (ref_clk domain)
  pcm_pkg::pcm_bus_req_t req;
  logic [5:0] loop_multiplier_q;
  logic [4:0] post_divider_q;
  logic [4:0] filter_ratio_q;
  logic wide_window_sel_q;
  logic ext_osc_enable_q;
  logic pll_bus_select_q;
  logic [2:0] watchdog_rate_sel_q;
  logic pll_settle_irq_en_q;
  logic osc_status_irq_en_q;
  logic pll_settle_change_flag_q;
  logic osc_status_change_flag_q;
  logic settled_q;
  logic qualified_q;
  logic ack_q;
  logic wr_en;
  logic [31:0] rd_d;

  assign req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};
  // one wait state per access, answer on second cycle
  assign avs_waitrequest = (req.read | req.write) & ~ack_q;
  assign wr_en = req.write & ack_q;

  always_ff @(posedge ref_clk)
  begin
    if (reset | ack_q)
      ack_q <= 1'b0;
    else
      ack_q <= req.read | req.write;
  end

  // ==========================================================
  // synchronised status from the vco domain
  logic lock_s1_q, lock_s2_q, qual_s1_q, qual_s2_q, noise_s1_q, noise_s2_q, noise_s3_q;
  logic osc_qual_vco_q;
  logic noise_tgl_q;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      qual_s1_q <= 1'b0;
      qual_s2_q <= 1'b0;
      noise_s1_q <= 1'b0;
      noise_s2_q <= 1'b0;
      noise_s3_q <= 1'b0;
    end
    else
    begin
      lock_s1_q <= pll_locked;
      lock_s2_q <= lock_s1_q;
      qual_s1_q <= osc_qual_vco_q;
      qual_s2_q <= qual_s1_q;
      noise_s1_q <= noise_tgl_q;
      noise_s2_q <= noise_s1_q;
      noise_s3_q <= noise_s2_q;
    end
  end

  logic noise_evt;
  logic settled_d;
  logic qualified_d;
  assign noise_evt = noise_s2_q ^ noise_s3_q;
  // noise drops settled; qualified follows settled
  assign settled_d = lock_s2_q & ~noise_evt;
  assign qualified_d = ext_osc_enable_q & qual_s2_q & settled_d;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      settled_q <= 1'b0;
      qualified_q <= 1'b0;
    end
    else
    begin
      settled_q <= settled_d;
      qualified_q <= qualified_d;
    end
  end

  // change flags set on status change, set wins over write-one clear
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pll_settle_change_flag_q <= 1'b0;
      osc_status_change_flag_q <= 1'b0;
    end
    else
    begin
      if (settled_d != settled_q || noise_evt)
        pll_settle_change_flag_q <= 1'b1;
      else if (wr_en && req.address == `PCM_OFF_FLAG && req.writedata[`PCM_FLG_SETTLE_CHG])
        pll_settle_change_flag_q <= 1'b0;
      if (qualified_d != qualified_q || noise_evt)
        osc_status_change_flag_q <= 1'b1;
      else if (wr_en && req.address == `PCM_OFF_FLAG && req.writedata[`PCM_FLG_OSC_CHG])
        osc_status_change_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      loop_multiplier_q <= `PCM_RST_SYN;
      post_divider_q <= `PCM_RST_POST;
      filter_ratio_q <= `PCM_RST_FILT;
      wide_window_sel_q <= 1'b0;
      ext_osc_enable_q <= 1'b0;
      watchdog_rate_sel_q <= 3'h0;
      pll_settle_irq_en_q <= 1'b0;
      osc_status_irq_en_q <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (req.address)
        `PCM_OFF_IRQEN:
        begin
          pll_settle_irq_en_q <= req.writedata[`PCM_IRQ_SETTLE];
          osc_status_irq_en_q <= req.writedata[`PCM_IRQ_OSC];
        end
        `PCM_OFF_OSC:
        begin
          ext_osc_enable_q <= req.writedata[`PCM_OSC_ENABLE];
          wide_window_sel_q <= req.writedata[`PCM_OSC_WIDE];
          filter_ratio_q <= req.writedata[4:0];
        end
        `PCM_OFF_WDOG: watchdog_rate_sel_q <= req.writedata[2:0];
        `PCM_OFF_SYN: loop_multiplier_q <= req.writedata[5:0];
        `PCM_OFF_POST: post_divider_q <= req.writedata[4:0];
        default: ;
      endcase
    end
  end

  // losing qualification in bypass forces pll select; set wins over write
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pll_bus_select_q <= 1'b1;
    else if (!pll_bus_select_q && qualified_q && !qualified_d)
      pll_bus_select_q <= 1'b1;
    else if (wr_en && req.address == `PCM_OFF_CLKS)
      pll_bus_select_q <= req.writedata[0];
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    unique case (req.address)
      `PCM_OFF_FLAG: rd_d[3:0] = {qualified_q, osc_status_change_flag_q, settled_q, pll_settle_change_flag_q};
      `PCM_OFF_IRQEN: rd_d[1:0] = {osc_status_irq_en_q, pll_settle_irq_en_q};
      `PCM_OFF_OSC: rd_d[7:0] = {ext_osc_enable_q, 1'b0, wide_window_sel_q, filter_ratio_q};
      `PCM_OFF_WDOG: rd_d[2:0] = watchdog_rate_sel_q;
      `PCM_OFF_SYN: rd_d[5:0] = loop_multiplier_q;
      `PCM_OFF_POST: rd_d[4:0] = post_divider_q;
      `PCM_OFF_CLKS: rd_d[0] = pll_bus_select_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      avs_readdata <= 32'h0000_0000;
    else if (req.read && !ack_q)
      avs_readdata <= rd_d;
  end

  // ==========================================================
  // mode, reset enables, multiplier
  pcm_pkg::pcm_mode_t mode_d;
  always_comb
  begin
    if (!ext_osc_enable_q)
      mode_d = pcm_pkg::PCM_PEI;
    else if (pll_bus_select_q)
      mode_d = pcm_pkg::PCM_PEE;
    else
      mode_d = pcm_pkg::PCM_PBE;
  end
  assign mode = mode_d;
  assign ref_is_external = ext_osc_enable_q;
  // internal mode keeps watchdog and tick on internal reference
  assign wdog_tick_internal_ref = (mode_d == pcm_pkg::PCM_PEI);
  // clock monitor gated by oscillator enable
  assign clock_monitor_reset = clock_monitor_fail & ext_osc_enable_q;
  assign watchdog_reset = watchdog_timeout & (watchdog_rate_sel_q != 3'h0);
  // reported loop multiplier, vco = 2 * ref * (n + 1)
  // multiplier 0x3f gives 128, hence the eighth bit
  assign vco_multiplier = {{1'b0, loop_multiplier_q} + 7'h01, 1'b0};

  // ==========================================================
  // oscillator filter and noise detector (vco_clock domain)
  logic cfg_s1_q, cfg_s2_q;
  logic xin_s1_q, xin_s2_q, xin_s3_q;
  logic [5:0] since_q;
  logic filt_q;
  logic [3:0] good_q;
  logic filter_on, detect_on, win_hit, win_early;
  logic [5:0] half;
  always_ff @(posedge vco_clock)
  begin
    if (vco_reset)
    begin
      xin_s1_q <= 1'b0;
      xin_s2_q <= 1'b0;
      xin_s3_q <= 1'b0;
      cfg_s1_q <= 1'b0;
      cfg_s2_q <= 1'b0;
    end
    else
    begin
      xin_s1_q <= crystal_input;
      xin_s2_q <= xin_s1_q;
      xin_s3_q <= xin_s2_q;
      cfg_s1_q <= ext_osc_enable_q;
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // filter and detect enables; ratio and width are quasi-static
  assign filter_on = (filter_ratio_q != 5'h00);
  assign detect_on = (filter_ratio_q >= 5'h04) || (filter_ratio_q >= 5'h02 && !wide_window_sel_q);
  assign half = {1'b0, filter_ratio_q};
  // window one cycle, or three cycles when wide
  assign win_hit = wide_window_sel_q ? (since_q + 6'h01 >= half - 6'h01 && since_q + 6'h01 <= half + 6'h01)
                                     : (since_q + 6'h01 == half);
  assign win_early = since_q + 6'h01 < (wide_window_sel_q ? half - 6'h01 : half);

  always_ff @(posedge vco_clock)
  begin
    if (vco_reset || !cfg_s2_q)
    begin
      since_q <= 6'h00;
      filt_q <= 1'b0;
      good_q <= 4'h0;
      osc_qual_vco_q <= 1'b0;
      noise_tgl_q <= 1'b0;
    end
    else if (!filter_on)
    begin
      filt_q <= xin_s2_q;
      osc_qual_vco_q <= 1'b1;
    end
    else if (xin_s2_q != xin_s3_q && !win_early)
    begin
      // edge accepted at or after window start; spikes before window are dropped
      since_q <= 6'h00;
      filt_q <= xin_s2_q;
      if (!win_hit && detect_on)
      begin
        noise_tgl_q <= ~noise_tgl_q;
        good_q <= 4'h0;
        osc_qual_vco_q <= 1'b0;
      end
      else if (good_q != `PCM_QUAL_EDGES)
        good_q <= good_q + 4'h1;
      else
        osc_qual_vco_q <= 1'b1;
    end
    else if (since_q != 6'h3f)
      since_q <= since_q + 6'h01;
  end
  assign ext_osc_clock = filt_q;

  // ==========================================================
  // pll output and bus clock dividers
  logic [4:0] post_cnt_q;
  logic pll_clk_q, lock_v1_q, lock_v2_q, bus_tgl_q, sel_v1_q, sel_v2_q;
  logic [4:0] post_eff;
  logic [4:0] post_nxt;
  always_ff @(posedge vco_clock)
  begin
    if (vco_reset)
    begin
      lock_v1_q <= 1'b0;
      lock_v2_q <= 1'b0;
      sel_v1_q <= 1'b1;
      sel_v2_q <= 1'b1;
    end
    else
    begin
      lock_v1_q <= settled_q;
      lock_v2_q <= lock_v1_q;
      sel_v1_q <= pll_bus_select_q;
      sel_v2_q <= sel_v1_q;
    end
  end
  // unsettled uses divide by four regardless of post divider
  assign post_eff = lock_v2_q ? post_divider_q : 5'h03;
  // pll period is post_eff + 1 vco cycles; divide by one leaves pll_out_clock high
  assign post_nxt = (post_cnt_q >= post_eff) ? 5'h00 : post_cnt_q + 5'h01;
  always_ff @(posedge vco_clock)
  begin
    if (vco_reset)
    begin
      post_cnt_q <= 5'h00;
      pll_clk_q <= 1'b0;
      bus_tgl_q <= 1'b0;
    end
    else
    begin
      post_cnt_q <= post_nxt;
      pll_clk_q <= (post_nxt <= (post_eff >> 1));
      // bus is half the pll output
      if (post_nxt == 5'h00)
        bus_tgl_q <= ~bus_tgl_q;
    end
  end
  assign pll_out_clock = pll_clk_q;
  // bypass bus clock pauses with filtered oscillator while unsettled
  assign bus_clock = sel_v2_q ? bus_tgl_q : (filt_q & lock_v2_q);

  // ==========================================================
  // checks
  a_noise_clears_status: assert property (@(posedge ref_clk) disable iff (reset)
    noise_evt |=> !settled_q && !qualified_q && pll_settle_change_flag_q) else $error("noise did not clear status");
  a_qual_needs_settled: assert property (@(posedge ref_clk) disable iff (reset)
    qualified_q |-> settled_q) else $error("qualified without settled");
  a_bypass_fallback: assert property (@(posedge ref_clk) disable iff (reset)
    (!pll_bus_select_q && qualified_q && !qualified_d) |=> pll_bus_select_q) else $error("no auto select");
  a_cm_reset_gate: assert property (@(posedge ref_clk) disable iff (reset)
    clock_monitor_reset |-> ext_osc_enable_q) else $error("clock monitor reset while oscillator off");
  a_wdog_reset_gate: assert property (@(posedge ref_clk) disable iff (reset)
    watchdog_reset |-> watchdog_rate_sel_q != 3'h0) else $error("watchdog reset while disabled");
  a_reset_config: assert property (@(posedge ref_clk)
    $past(reset) && !reset |-> post_divider_q == 5'h03 && loop_multiplier_q == 6'h1f && mode == 2'(pcm_pkg::PCM_PEI))
    else $error("bad reset configuration");
  a_unsettled_div4: assert property (@(posedge vco_clock) disable iff (vco_reset)
    !lock_v2_q |-> post_eff == 5'h03) else $error("unsettled divider not four");
  a_internal_ref_tick: assert property (@(posedge ref_clk) disable iff (reset)
    !ext_osc_enable_q |-> wdog_tick_internal_ref) else $error("tick not on internal reference");
endmodule

/* File: verification/test_pll_clock_mode_osc_filter.sv */
// self-checking bench for the clock mode unit
`timescale 1ns/1ps
`include "pcm_map.svh"
module test_pll_clock_mode_osc_filter;
  logic ref_clk = 1'b0;
  logic vco_clock = 1'b0;
  logic reset = 1'b1;
  logic vco_reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pll_locked = 1'b0;
  logic crystal_input = 1'b0;
  logic clock_monitor_fail = 1'b0;
  logic watchdog_timeout = 1'b0;
  logic ext_osc_clock, pll_out_clock, bus_clock, ref_is_external, wdog_tick_internal_ref;
  logic clock_monitor_reset, watchdog_reset;
  logic [1:0] mode;
  logic [7:0] vco_multiplier;
  logic late = 1'b0;
  logic [31:0] seed = 32'h0000_000d;
  logic [31:0] rd;
  logic [31:0] v;
  logic [3:0] a;
  int xcnt = 0;
  int per;
  int n;
  int n_fail = 0;
  int num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;
  // vco just below 25 MHz, so the narrow window is legal
  always #21 vco_clock = ~vco_clock;

  // osc at vco/8, ratio field 4
  always @(posedge vco_clock)
  begin
    xcnt <= xcnt + 1;
    if (xcnt + 1 >= 4 + (late ? 2 : 0))
    begin
      crystal_input <= ~crystal_input;
      xcnt <= 0;
      late <= 1'b0;
    end
  end

  pcm_clock_mode DUT (
    .ref_clk(ref_clk),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .vco_clock(vco_clock),
    .vco_reset(vco_reset),
    .pll_locked(pll_locked),
    .crystal_input(crystal_input),
    .clock_monitor_fail(clock_monitor_fail),
    .watchdog_timeout(watchdog_timeout),
    .ext_osc_clock(ext_osc_clock),
    .pll_out_clock(pll_out_clock),
    .bus_clock(bus_clock),
    .mode(mode),
    .ref_is_external(ref_is_external),
    .wdog_tick_internal_ref(wdog_tick_internal_ref),
    .clock_monitor_reset(clock_monitor_reset),
    .watchdog_reset(watchdog_reset),
    .vco_multiplier(vco_multiplier)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // vco cycles per pll period: fixed /4 while unsettled
  function automatic int pll_div(input logic settled, input logic [4:0] post);
    return settled ? int'(post) + 1 : 4;
  endfunction

  function automatic logic [31:0] mult_exp(input logic [5:0] m);
    return 32'({1'b0, m}) * 2 + 2;
  endfunction

  task automatic final_report();
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic mchk(input pcm_pkg::pcm_mode_t m);
    chk("mode", {30'h0, m}, {30'h0, mode});
  endtask

  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_address <= adr;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [3:0] adr, input logic [31:0] exp, input string what);
    bus(1'b0, adr, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  // counts vco edges between two rising edges of the chosen clock
  task automatic pchk(input logic which, input int exp, input string what);
    logic p, c;
    int k, s;
    k = 0;
    s = 0;
    per = -1;
    p = which ? bus_clock : pll_out_clock;
    for (int i = 0; i < 300 && per < 0; i++)
    begin
      @(posedge vco_clock);
      c = which ? bus_clock : pll_out_clock;
      k++;
      if (c && !p)
      begin
        if (s == 1)
          per = k;
        s = 1;
        k = 0;
      end
      p = c;
    end
    chk(what, 32'(exp), 32'(per));
  endtask

  // ==========================================================
  // watchdog
  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    vco_reset <= 1'b0;
    rchk(`PCM_OFF_SYN, 32'h0000_001f, "multiplier");
    rchk(`PCM_OFF_POST, 32'h0000_0003, "post_divider");
    rchk(`PCM_OFF_CLKS, 32'h0000_0001, "pll_bus_select");
    rchk(`PCM_OFF_OSC, 32'h0000_0000, "osc_control");
    mchk(pcm_pkg::PCM_PEI);
    chk("vco_multiplier", mult_exp(6'h1f), {24'h0, vco_multiplier});
    chk("wdog_tick_internal_ref", 32'h1, {31'h0, wdog_tick_internal_ref});
    chk("ref_is_external", 32'h0, {31'h0, ref_is_external});
    pchk(1'b0, pll_div(1'b0, 5'h03), "pll_period");
    pchk(1'b1, 2 * pll_div(1'b0, 5'h03), "bus_period");
    repeat (6)
    begin
      v = xs();
      a = 4'h7 + 4'(v[11:8] % 4'h9);
      bus(1'b1, `PCM_OFF_SYN, {26'h0, v[5:0]});
      chk("vco_multiplier", mult_exp(v[5:0]), {24'h0, vco_multiplier});
      rchk(`PCM_OFF_SYN, {26'h0, v[5:0]}, "multiplier");
      bus(1'b1, a, v);
      rchk(a, 32'h0000_0000, "unmapped");
    end
    bus(1'b1, `PCM_OFF_SYN, 32'h0000_001f);
    @(posedge ref_clk);
    watchdog_timeout <= 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      bus(1'b1, `PCM_OFF_WDOG, 32'(r));
      chk("watchdog_reset", 32'(r != 0), {31'h0, watchdog_reset});
    end
    @(posedge ref_clk);
    watchdog_timeout <= 1'b0;
    clock_monitor_fail <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("clock_monitor_reset", 32'h0, {31'h0, clock_monitor_reset});
    bus(1'b1, `PCM_OFF_POST, 32'h0000_0007);
    bus(1'b1, `PCM_OFF_OSC, 32'h0000_0004);
    bus(1'b1, `PCM_OFF_OSC, 32'h0000_0084);
    chk("clock_monitor_reset", 32'h1, {31'h0, clock_monitor_reset});
    mchk(pcm_pkg::PCM_PEE);
    chk("ref_is_external", 32'h1, {31'h0, ref_is_external});
    @(posedge ref_clk);
    clock_monitor_fail <= 1'b0;
    pll_locked <= 1'b1;
    // wait settled and qualified, then clear flags
    n = 0;
    do
    begin
      bus(1'b0, `PCM_OFF_FLAG, 32'h0000_0000);
      n++;
    end
    while ((rd & 32'h0000_000a) != 32'h0000_000a && n < 400);
    chk("settled_qualified", 32'h0000_000a, rd & 32'h0000_000a);
    pchk(1'b0, pll_div(1'b1, 5'h07), "pll_period");
    pchk(1'b1, 2 * pll_div(1'b1, 5'h07), "bus_period");
    bus(1'b1, `PCM_OFF_FLAG, 32'h0000_0005);
    rchk(`PCM_OFF_FLAG, 32'h0000_000a, "flags");
    bus(1'b1, `PCM_OFF_IRQEN, 32'h0000_0003);
    rchk(`PCM_OFF_IRQEN, 32'h0000_0003, "irq_enable");
    // bypass entry ends with select cleared
    bus(1'b1, `PCM_OFF_CLKS, 32'h0000_0000);
    mchk(pcm_pkg::PCM_PBE);
    pchk(1'b1, 8, "bus_period_osc");
    // late edge, two vco cycles outside the narrow window
    @(posedge ref_clk);
    late <= 1'b1;
    repeat (100) @(posedge ref_clk);
    bus(1'b0, `PCM_OFF_FLAG, 32'h0000_0000);
    chk("noise_flags", 32'h0000_0005, rd & 32'h0000_000d);
    rchk(`PCM_OFF_CLKS, 32'h0000_0001, "pll_bus_select");
    mchk(pcm_pkg::PCM_PEE);
    @(posedge ref_clk);
    pll_locked <= 1'b0;
    repeat (20) @(posedge ref_clk);
    bus(1'b0, `PCM_OFF_FLAG, 32'h0000_0000);
    chk("status_lost", 32'h0000_0000, rd & 32'h0000_000a);
    pchk(1'b0, pll_div(1'b0, 5'h07), "pll_period");
    pchk(1'b1, 2 * pll_div(1'b0, 5'h07), "bus_period");
    // software side of stop entry: both irq enables off
    bus(1'b1, `PCM_OFF_IRQEN, 32'h0000_0000);
    rchk(`PCM_OFF_IRQEN, 32'h0000_0000, "irq_enable");
    final_report();
  end
endmodule
